// ==== bench/swt_host_model.sv ====
// Host CPU model: builds descriptors of frames sent with a special tag
`timescale 1ns/10ps
`include "swt_consts.svh"
module swt_host_model (
  input wire logic [6:0] vidBits,
  output swt_pkg::swt_desc_s desc
);
  import swt_pkg::*;
  // Frame from the CPU port with special tag then a real VLAN tag
  always_comb begin
    desc = '0;
    desc.srcPort = 2'h0;
    desc.tagCount = 2'h2;
    desc.firstTpid = `SWT_VLAN_TPID;
    // Never an all-zero VID: bit 7 is unused on ingress
    desc.firstVid = (vidBits == 7'h00) ? 12'h080 : {5'h00, vidBits};
    desc.frameLen = 12'h040;
  end
endmodule : swt_host_model

// ==== bench/swt_tb_top.sv ====
// Self-checking bench for the trap, mirror and CPU tag engine
`timescale 1ns/10ps
`include "swt_consts.svh"
module tb_top;
  import swt_pkg::*;
  logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, pktValid, decValid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] hostVid; // Special tag VID bits fed to the host model
  swt_desc_s pktDesc, hostDesc, d;
  swt_dec_s decOut, dec; // Last decision captured
  int errorCnt, checks;
  // Design under test, bus ready looped back
  swt_engine DUT (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pktValid(pktValid),
    .pktDesc(pktDesc), .decValid(decValid), .decOut(decOut));
  // Host CPU on the far side
  swt_host_model host (.vidBits(hostVid), .desc(hostDesc));
  // Clock; reset comes from the main sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Watchdog cuts a hang short
  initial begin
    #400000;
    errorCnt++;
    stopTest();
  end
  task automatic stopTest();
    if (errorCnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stopTest
  // Compare one value
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One AHB-Lite single word transfer, waits on ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= `SWT_HSIZE_WORD;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb
  // Send one descriptor and check the destination set
  task automatic send(input swt_desc_s x, input logic [2:0] expMask);
    pktValid <= 1'b1;
    pktDesc <= x;
    @(posedge sys_clk);
    pktValid <= 1'b0;
    @(posedge sys_clk);
    dec = decOut;
    check("decValid", 32'h1, {31'h0, decValid});
    check("destMask", {29'h0, expMask}, {29'h0, dec.destMask});
  endtask : send
  // Plain descriptor with a known table hit
  function automatic swt_desc_s mk(input logic [1:0] src, input logic [2:0] ports);
    mk = '0;
    mk.srcPort = src;
    mk.hit = 1'b1;
    mk.entPorts = ports;
    mk.frameLen = 12'h040;
  endfunction : mk
  // Registers: reset value, readback, unmapped place
  task automatic tRegs();
    ahb(1'b0, `SWT_OFF_INKIND, 32'h0);
    check("inKindRst", 32'h0, rd);
    ahb(1'b1, `SWT_OFF_MIR, 32'hffff_ffff);
    ahb(1'b0, `SWT_OFF_MIR, 32'h0);
    check("mirror", 32'h0000_00ff, rd);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
    ahb(1'b1, `SWT_OFF_MIR, 32'h0);
  endtask : tRegs
  // IGMP trap, echo and source-state drop
  task automatic tIgmp();
    ahb(1'b1, `SWT_OFF_GIC, 32'h01);
    d = mk(2'h1, 3'b100);
    d.ipv4 = 1'b1;
    d.mcast = 1'b1;
    d.ipProto = `SWT_PROTO_IGMP;
    send(d, 3'b001);
    check("monitored", 32'h1, {31'h0, dec.monitored});
    d.ipProto = 8'h03;
    send(d, 3'b100);
    d.ipProto = `SWT_PROTO_IGMP;
    d.srcPort = 2'h0;
    send(d, 3'b000);
    ahb(1'b1, `SWT_OFF_GIC, 32'h11);
    send(d, 3'b001);
    ahb(1'b1, `SWT_OFF_STATE, 32'h0c);
    d.srcPort = 2'h1;
    send(d, 3'b000);
    check("drop", 32'h1, {31'h0, dec.drop});
    ahb(1'b1, `SWT_OFF_STATE, 32'h0);
  endtask : tIgmp
  // MLD trap with other headers, any hop-by-hop and parse limit
  task automatic tMld();
    logic [7:0] nh [5] = '{`SWT_NH_ROUTING, `SWT_NH_FRAG, `SWT_NH_ESP, `SWT_NH_AH,
      `SWT_NH_DEST};
    ahb(1'b1, `SWT_OFF_GIC, 32'h02);
    d = mk(2'h1, 3'b100);
    d.ipv6 = 1'b1;
    d.mcast = 1'b1;
    d.nextHdr = `SWT_NH_MLD;
    send(d, 3'b001);
    d.nextHdr = `SWT_NH_ROUTING;
    send(d, 3'b100);
    ahb(1'b1, `SWT_OFF_GIC, 32'h06);
    foreach (nh[i]) begin
      d.nextHdr = nh[i];
      send(d, 3'b001);
    end
    ahb(1'b1, `SWT_OFF_GIC, 32'h0a);
    d.nextHdr = 8'h00;
    d.hbhPresent = 1'b1;
    d.hbhNextHdr = 8'h11;
    d.hbhOffset = 7'h14;
    send(d, 3'b001);
    d.hbhOffset = `SWT_PARSE_LIMIT;
    send(d, 3'b100);
    ahb(1'b1, `SWT_OFF_GIC, 32'h0);
  endtask : tMld
  // Receive, transmit and sniffer-port mirroring
  task automatic tMirror();
    ahb(1'b1, `SWT_OFF_MIR, 32'h21);
    send(mk(2'h2, 3'b010), 3'b011);
    d = mk(2'h2, 3'b010);
    d.filtered = 1'b1;
    send(d, 3'b000);
    ahb(1'b1, `SWT_OFF_MIR, 32'h25);
    send(d, 3'b001);
    ahb(1'b1, `SWT_OFF_MIR, 32'h22);
    send(mk(2'h1, 3'b100), 3'b101);
    ahb(1'b1, `SWT_OFF_MIR, 32'h09);
    send(mk(2'h0, 3'b010), 3'b010);
    ahb(1'b1, `SWT_OFF_MIR, 32'h0);
    // Frame length limit on the CPU port
    d = mk(2'h0, 3'b010);
    d.frameLen = `SWT_LEN_TAGGED;
    send(d, 3'b010);
    d.frameLen = `SWT_LEN_TAGGED + 12'h1;
    send(d, 3'b000);
    ahb(1'b1, `SWT_OFF_RXCFG, 32'h1);
    send(d, 3'b010);
    ahb(1'b1, `SWT_OFF_RXCFG, 32'h0);
  endtask : tMirror
  // Special tag from the CPU: destination, broadcast, forced send
  task automatic tSpecial();
    ahb(1'b1, `SWT_OFF_INKIND, 32'h3);
    hostVid <= 7'h02;
    @(posedge sys_clk);
    send(hostDesc, 3'b100);
    check("stripMask", 32'h4, {29'h0, dec.stripMask});
    hostVid <= 7'h03;
    @(posedge sys_clk);
    send(hostDesc, 3'b110);
    ahb(1'b1, `SWT_OFF_STATE, 32'h10);
    hostVid <= 7'h02;
    @(posedge sys_clk);
    send(hostDesc, 3'b000);
    hostVid <= 7'h12;
    @(posedge sys_clk);
    send(hostDesc, 3'b100);
    ahb(1'b1, `SWT_OFF_STATE, 32'h0);
    // Lookup request with learning, then priority from contents
    ahb(1'b1, `SWT_OFF_VLAN, 32'h1);
    hostVid <= 7'h08;
    @(posedge sys_clk);
    d = hostDesc;
    d.entPorts = 3'b110;
    d.firstPri = 3'h6;
    d.contentPri = 3'h2;
    send(d, 3'b110);
    check("learn", 32'h1, {31'h0, dec.learn});
    check("pri", 32'h6, {29'h0, dec.pri});
    d.firstVid = 12'h022;
    send(d, 3'b100);
    check("priCalc", 32'h2, {29'h0, dec.pri});
    ahb(1'b1, `SWT_OFF_VLAN, 32'h0);
    ahb(1'b1, `SWT_OFF_INKIND, 32'h0);
  endtask : tSpecial
  // Tag inserted toward the CPU with entry fields
  task automatic tEgress();
    ahb(1'b1, `SWT_OFF_EGKIND, 32'h3);
    d = mk(2'h1, 3'b001);
    d.entStatic = 1'b1;
    d.entOverride = 1'b1;
    d.entPriEn = 1'b1;
    d.entPri = 3'h5;
    send(d, 3'b001);
    check("tagMask", 32'h1, {29'h0, dec.tagMask});
    check("egressVid", 32'h2f1, {20'h0, dec.egressVid});
    d.entStatic = 1'b0;
    send(d, 3'b001);
    check("egressVidLrn", 32'h001, {20'h0, dec.egressVid});
    ahb(1'b1, `SWT_OFF_EGKIND, 32'h0);
  endtask : tEgress
  // Main sequence
  initial begin
    {hsel, hwrite, pktValid, rst_b} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = `SWT_HSIZE_WORD;
    hostVid = 7'h00;
    pktDesc = '0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    tRegs();
    tIgmp();
    tMld();
    tMirror();
    tSpecial();
    tEgress();
    stopTest();
  end
endmodule : tb_top

// ==== verilog/swt_classify.sv ====
// Trap classifier and special tag decoder
`timescale 1ns/10ps
`include "swt_consts.svh"
module swt_classify (
  input swt_pkg::swt_desc_s desc,
  input swt_pkg::swt_gic_s gic,
  input wire logic [1:0] inKind,
  output swt_pkg::swt_cls_s cls
);
  import swt_pkg::*;

  // Next header match, with optional extension headers
  function automatic logic nhHit(input logic [7:0] nh, input logic other);
    nhHit = (nh == `SWT_NH_MLD) ||
      (other && (nh == `SWT_NH_ROUTING || nh == `SWT_NH_FRAG ||
      nh == `SWT_NH_ESP || nh == `SWT_NH_AH || nh == `SWT_NH_DEST));
  endfunction : nhHit

  logic hbhOk; // Hop-by-hop field lies inside the parse window

  // Classify the packet and decode the first tag
  always_comb begin
    cls = '0;
    hbhOk = desc.hbhPresent && (desc.hbhOffset < `SWT_PARSE_LIMIT);
    // Special tag only in the standard tag slot
    cls.special = (inKind == `SWT_KIND_SPECIAL) && (desc.tagCount != 2'b00) &&
      (desc.firstTpid == `SWT_VLAN_TPID);
    // CPU-sent group traffic is not trapped back
    cls.igmp = gic.igmpEn && desc.ipv4 && desc.mcast && !cls.special &&
      (desc.ipProto == `SWT_PROTO_IGMP);
    cls.mld = gic.mldEn && desc.ipv6 && desc.mcast && !cls.special &&
      (nhHit(desc.nextHdr, gic.otherNh) ||
      (hbhOk && (gic.anyHbh || nhHit(desc.hbhNextHdr, gic.otherNh))));
    cls.lookup = desc.firstVid[`SWT_VID_LOOKUP];
    cls.forceFwd = desc.firstVid[`SWT_VID_FORCE];
    cls.destIdx = desc.firstVid[1:0];
    cls.priCalc = desc.firstVid[`SWT_VID_PRICALC];
    cls.vlanRules = desc.firstVid[`SWT_VID_VLANRULES];
  end
endmodule : swt_classify

// ==== verilog/swt_consts.svh ====
// Offsets, reset values, codes and limits for the switch trap/mirror/tag engine
// Notes on behaviour
// - Trap IPv4 multicast protocol 2 to monitor
// - Trap IPv6 multicast next header 58 to monitor
// - Option adds headers 43,44,50,51,60 for trapping
// - Option accepts any hop-by-hop next header
// - Parse only first 64 bytes of header
// - Never send back to receiver, except echo option
// - Drop monitored on disabled or blocked source
// - Drop monitored on the three VLAN faults
// - Many mirrored ports, exactly one sniffer port
// - Receive mirroring copies forwarded packets to sniffer
// - Transmit mirroring copies packets sent to mirrored
// - No filtered mirroring unless enabled; never to receiver
// - Ingress kind 11b decodes first tag specially
// - Tag bits 0-1 pick destination, bit 4 forces
// - Tag bit 3 does lookup, learning, entry override
// - Tag bit 5 picks priority from packet contents
// - Tag bit 6 applies VLAN rules, second tag
// - Strip special tag; real tag follows it
// - CPU port takes tagged frames up to 1522
// - Egress kind 11b inserts tag toward CPU
// - Egress tag carries priority, source, monitored flag
// - Egress tag carries entry override, static, priority
// - Entry bits zero for learned or missing entries
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH
`define SWT_OFF_GIC 8'h00
`define SWT_OFF_MIR 8'h04
`define SWT_OFF_INKIND 8'h08
`define SWT_OFF_EGKIND 8'h0c
`define SWT_OFF_VLAN 8'h10
`define SWT_OFF_STATE 8'h14
`define SWT_OFF_RXCFG 8'h18
`define SWT_OFF_STATUS 8'h1c
`define SWT_RST_KIND 6'h00
`define SWT_RST_STATE 6'h00
`define SWT_KIND_SPECIAL 2'b11
`define SWT_STP_FWD 2'b00
`define SWT_STP_BLOCK 2'b01
`define SWT_STP_LEARN 2'b10
`define SWT_STP_DISABLED 2'b11
`define SWT_PROTO_IGMP 8'h02
`define SWT_NH_MLD 8'h3a
`define SWT_NH_ROUTING 8'h2b
`define SWT_NH_FRAG 8'h2c
`define SWT_NH_ESP 8'h32
`define SWT_NH_AH 8'h33
`define SWT_NH_DEST 8'h3c
`define SWT_PARSE_LIMIT 7'h40
`define SWT_VID_RSVD 12'hfff
`define SWT_VLAN_TPID 16'h8100
`define SWT_LEN_TAGGED 12'h5f2
`define SWT_LEN_LONG 12'h800
`define SWT_VID_LOOKUP 3
`define SWT_VID_FORCE 4
`define SWT_VID_PRICALC 5
`define SWT_VID_VLANRULES 6
`define SWT_HSIZE_WORD 3'b010
`endif

// ==== verilog/swt_engine.sv ====
// Switch trap, mirror and CPU tag decision engine with AHB-Lite registers
`timescale 1ns/10ps
`include "swt_consts.svh"
module swt_engine (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pktValid,
  input swt_pkg::swt_desc_s pktDesc,
  output logic decValid,
  output swt_pkg::swt_dec_s decOut
);
  import swt_pkg::*;

  // One-hot mask of a port index; index 3 gives none
  function automatic logic [2:0] portBit(input logic [1:0] idx);
    portBit = 3'b001 << idx;
  endfunction : portBit

  // Two-bit per-port field select
  function automatic logic [1:0] fieldOf(input logic [5:0] v, input logic [1:0] idx);
    fieldOf = v[{idx, 1'b0} +: 2];
  endfunction : fieldOf

  // Configuration registers
  swt_gic_s gic; // Global ingress configuration
  swt_gic_s next_gic;
  swt_mir_s mir; // Mirror configuration
  swt_mir_s next_mir;
  logic [5:0] inKind; // Ingress port kinds
  logic [5:0] next_inKind;
  logic [5:0] egKind; // Egress port kinds
  logic [5:0] next_egKind;
  swt_vlan_s vcfg; // Per-port ingress configuration
  swt_vlan_s next_vcfg;
  logic [5:0] portState; // Spanning tree states
  logic [5:0] next_portState;
  logic longFrame; // Long frame enable on port 0
  logic next_longFrame;
  logic [15:0] monCount; // Monitored packet count
  logic [15:0] next_monCount;
  logic [15:0] mirCount; // Mirrored packet count
  logic [15:0] next_mirCount;
  // Bus phase state
  logic wrPend; // Write data phase pending
  logic next_wrPend;
  logic [7:0] wrAddr; // Address of the pending write
  logic [7:0] next_wrAddr;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic rdAcc; // Read accepted in this address phase
  // Decision path
  swt_cls_s cls; // Classifier output
  swt_dec_s next_dec;
  logic next_decValid;
  logic [1:0] srcSt; // State of the receiving port
  logic [2:0] srcBit; // Receiving port mask
  logic stpOvr; // Spanning tree override in force
  logic vlanOn; // VLAN rules in force
  logic vlanDrop; // VLAN ingress fault
  logic srcBlocked; // Receiving port may not forward
  logic tooLong; // Frame over the port 0 limit
  logic rxM; // Receive mirror copy
  logic txM; // Transmit mirror copy
  logic [2:0] kind11; // Ports whose egress kind inserts a tag

  swt_classify u_cls (
    .desc(pktDesc),
    .gic(gic),
    .inKind(fieldOf(inKind, pktDesc.srcPort)),
    .cls(cls)
  );

  // Bus slave and register next values
  always_comb begin
    next_gic = gic;
    next_mir = mir;
    next_inKind = inKind;
    next_egKind = egKind;
    next_vcfg = vcfg;
    next_portState = portState;
    next_longFrame = longFrame;
    next_hreadyout = 1'b1;
    // Only whole-word writes are taken; reads are accepted at any size
    next_wrPend = hsel && htrans[1] && hready && hwrite && (hsize == `SWT_HSIZE_WORD);
    next_wrAddr = next_wrPend ? haddr[7:0] : wrAddr;
    rdAcc = hsel && htrans[1] && hready && !hwrite;
    // Write in the data phase; unmapped writes are ignored
    if (wrPend) begin
      if (wrAddr == `SWT_OFF_GIC) begin
        next_gic = swt_gic_s'(hwdata[7:0]);
      end else if (wrAddr == `SWT_OFF_MIR) begin
        next_mir = swt_mir_s'(hwdata[7:0]);
      end else if (wrAddr == `SWT_OFF_INKIND) begin
        next_inKind = hwdata[5:0];
      end else if (wrAddr == `SWT_OFF_EGKIND) begin
        next_egKind = hwdata[5:0];
      end else if (wrAddr == `SWT_OFF_VLAN) begin
        next_vcfg = swt_vlan_s'(hwdata[11:0]);
      end else if (wrAddr == `SWT_OFF_STATE) begin
        next_portState = hwdata[5:0];
      end else if (wrAddr == `SWT_OFF_RXCFG) begin
        next_longFrame = hwdata[0];
      end
    end
    // Read from next values so a write just before is seen
    next_hrdata = 32'h0;
    if (rdAcc) begin
      if (haddr[7:0] == `SWT_OFF_GIC) begin
        next_hrdata = {24'h0, next_gic};
      end else if (haddr[7:0] == `SWT_OFF_MIR) begin
        next_hrdata = {24'h0, next_mir};
      end else if (haddr[7:0] == `SWT_OFF_INKIND) begin
        next_hrdata = {26'h0, next_inKind};
      end else if (haddr[7:0] == `SWT_OFF_EGKIND) begin
        next_hrdata = {26'h0, next_egKind};
      end else if (haddr[7:0] == `SWT_OFF_VLAN) begin
        next_hrdata = {20'h0, next_vcfg};
      end else if (haddr[7:0] == `SWT_OFF_STATE) begin
        next_hrdata = {26'h0, next_portState};
      end else if (haddr[7:0] == `SWT_OFF_RXCFG) begin
        next_hrdata = {31'h0, next_longFrame};
      end else if (haddr[7:0] == `SWT_OFF_STATUS) begin
        next_hrdata = {next_mirCount, next_monCount};
      end
    end
  end

  // Forwarding decision for one descriptor
  always_comb begin
    next_dec = '0;
    next_decValid = pktValid;
    srcBit = portBit(pktDesc.srcPort);
    srcSt = fieldOf(portState, pktDesc.srcPort);
    kind11 = '0;
    for (int i = 0; i < 3; i++) begin
      kind11[i] = (egKind[2*i +: 2] == `SWT_KIND_SPECIAL);
    end
    // Override comes from the tag or from the entry
    stpOvr = (cls.special && !cls.lookup) ? cls.forceFwd : pktDesc.entOverride;
    vlanOn = gic.vlanEn && (!cls.special || cls.vlanRules);
    vlanDrop = vlanOn && ((vcfg.admitOnly[pktDesc.srcPort] &&
      (pktDesc.tagCount == 2'b00 || pktDesc.firstVid == 12'h0)) ||
      (pktDesc.tagCount != 2'b00 && !cls.special && pktDesc.firstVid == `SWT_VID_RSVD) ||
      (vcfg.memberCheck[pktDesc.srcPort] && !vcfg.admitNonMember[pktDesc.srcPort] &&
      !pktDesc.srcMember));
    srcBlocked = (srcSt == `SWT_STP_DISABLED) ||
      ((srcSt == `SWT_STP_LEARN || srcSt == `SWT_STP_BLOCK) && !stpOvr);
    tooLong = (pktDesc.srcPort == 2'd0) &&
      (pktDesc.frameLen > (longFrame ? `SWT_LEN_LONG : `SWT_LEN_TAGGED));
    next_dec.srcPort = pktDesc.srcPort;
    next_dec.monitored = cls.igmp || cls.mld;
    next_dec.learn = (!cls.special || cls.lookup) && vcfg.learnEn[pktDesc.srcPort] &&
      (srcSt == `SWT_STP_FWD || srcSt == `SWT_STP_LEARN) && !next_dec.monitored;
    if (next_dec.monitored) begin
      // Trapped: most rules skipped
      next_dec.destMask = portBit(gic.monPort);
      if (!gic.echo) begin
        next_dec.destMask = next_dec.destMask & ~srcBit;
      end
      next_dec.drop = srcBlocked || vlanDrop;
    end else begin
      if (cls.special && !cls.lookup) begin
        // Tag names the destination
        next_dec.destMask = (cls.destIdx == 2'd3) ? 3'b111 : portBit(cls.destIdx);
      end else begin
        next_dec.destMask = pktDesc.entPorts;
      end
      if (vlanOn) begin
        next_dec.destMask = next_dec.destMask & pktDesc.vlanMembers;
      end
      // Non-forwarding destinations need an override
      for (int i = 0; i < 3; i++) begin
        if (egressBlocked(portState[2*i +: 2]) && !stpOvr) begin
          next_dec.destMask[i] = 1'b0;
        end
      end
      next_dec.destMask = next_dec.destMask & ~srcBit;
      // Zero VID on the CPU port reads as priority tagged
      next_dec.drop = srcBlocked || vlanDrop || tooLong || (!cls.special &&
        pktDesc.filtered) || (cls.special && gic.vlanEn &&
        vcfg.admitOnly[pktDesc.srcPort] && pktDesc.firstVid == 12'h0);
    end
    next_dec.pri = (cls.special && !cls.priCalc) ? pktDesc.firstPri :
      pktDesc.contentPri;
    // Mirror copies, never to the receiving port
    rxM = mir.rxEn && mir.mirrored[pktDesc.srcPort] && (!next_dec.drop || mir.rxFilt);
    txM = mir.txEn && !next_dec.drop && ((next_dec.destMask & mir.mirrored) != 3'b000);
    if (next_dec.drop) begin
      next_dec.destMask = 3'b000;
    end
    if ((rxM || txM) && mir.sniffer != pktDesc.srcPort) begin
      next_dec.destMask = next_dec.destMask | portBit(mir.sniffer);
    end
    next_dec.tagMask = next_dec.destMask & kind11;
    next_dec.stripMask = cls.special ? (next_dec.destMask & ~kind11) : 3'b000;
    next_dec.egressVid[1:0] = pktDesc.srcPort;
    next_dec.egressVid[3] = next_dec.monitored;
    // Entry report only for host-added entries
    if (pktDesc.hit && pktDesc.entStatic) begin
      next_dec.egressVid[9:4] = {pktDesc.entPri, pktDesc.entPriEn, 1'b1,
        pktDesc.entOverride};
    end
    next_monCount = monCount + {15'h0, pktValid && next_dec.monitored};
    next_mirCount = mirCount + {15'h0, pktValid && (rxM || txM) &&
      mir.sniffer != pktDesc.srcPort};
  end

  // Destination state that blocks normal transmission
  function automatic logic egressBlocked(input logic [1:0] st);
    egressBlocked = (st != `SWT_STP_FWD);
  endfunction : egressBlocked

  // Register stage for bus and decision
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gic <= '0;
      mir <= '0;
      inKind <= `SWT_RST_KIND;
      egKind <= `SWT_RST_KIND;
      vcfg <= '0;
      portState <= `SWT_RST_STATE;
      longFrame <= 1'b0;
      monCount <= 16'h0;
      mirCount <= 16'h0;
      wrPend <= 1'b0;
      wrAddr <= 8'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      decValid <= 1'b0;
      decOut <= '0;
    end else begin
      gic <= next_gic;
      mir <= next_mir;
      inKind <= next_inKind;
      egKind <= next_egKind;
      vcfg <= next_vcfg;
      portState <= next_portState;
      longFrame <= next_longFrame;
      monCount <= next_monCount;
      mirCount <= next_mirCount;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      decValid <= next_decValid;
      decOut <= next_dec;
    end
  end

  // Checks on the decision path
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_igmp_trap: assert property (pktValid && gic.igmpEn && pktDesc.ipv4 && pktDesc.mcast &&
    !cls.special && pktDesc.ipProto == `SWT_PROTO_IGMP |=> decValid && decOut.monitored)
    else $error("IGMP packet not trapped");
  a_mld_trap: assert property (pktValid && gic.mldEn && pktDesc.ipv6 && pktDesc.mcast &&
    !cls.special && pktDesc.nextHdr == `SWT_NH_MLD |=> decOut.monitored)
    else $error("MLD packet not trapped");
  a_other_nh: assert property (pktValid && gic.mldEn && gic.otherNh && pktDesc.ipv6 &&
    pktDesc.mcast && !cls.special && pktDesc.nextHdr == `SWT_NH_ROUTING
    |=> decOut.monitored)
    else $error("Extension header not trapped");
  a_parse_limit: assert property (pktValid && !gic.otherNh && pktDesc.ipv6 &&
    pktDesc.nextHdr != `SWT_NH_MLD && pktDesc.hbhOffset >= `SWT_PARSE_LIMIT &&
    !pktDesc.ipv4 |=> !decOut.monitored)
    else $error("Header beyond parse window matched");
  a_no_src_out: assert property (decValid && !(decOut.monitored && $past(gic.echo))
    |-> (decOut.destMask & portBit(decOut.srcPort)) == 3'b000)
    else $error("Packet sent back to receiving port");
  a_mon_blocked: assert property (pktValid && (cls.igmp || cls.mld) &&
    srcSt == `SWT_STP_DISABLED |=> decOut.drop && decOut.monitored)
    else $error("Monitored packet from disabled port kept");
  a_vid_rsvd: assert property (pktValid && gic.vlanEn && !cls.special &&
    pktDesc.tagCount != 2'b00 && pktDesc.firstVid == `SWT_VID_RSVD |=> decOut.drop)
    else $error("Reserved VID not dropped");
  a_rx_mirror: assert property (pktValid && mir.rxEn && mir.mirrored[pktDesc.srcPort] &&
    mir.sniffer != pktDesc.srcPort && !next_dec.drop
    |=> decOut.destMask[$past(mir.sniffer)])
    else $error("Receive mirror copy missing");
  a_special_dest: assert property (pktValid && cls.special && !cls.lookup && cls.forceFwd &&
    !cls.vlanRules && pktDesc.firstVid[1:0] == 2'd1 && pktDesc.srcPort != 2'd1 &&
    !next_dec.drop |=> decOut.destMask[1])
    else $error("Special tag destination ignored");
  a_too_long: assert property (pktValid && pktDesc.srcPort == 2'd0 && !longFrame &&
    !(cls.igmp || cls.mld) && pktDesc.frameLen > `SWT_LEN_TAGGED |=> decOut.drop)
    else $error("Oversize CPU frame kept");
  a_tag_src: assert property (decValid |-> decOut.egressVid[1:0] == decOut.srcPort &&
    decOut.egressVid[3] == decOut.monitored)
    else $error("Egress tag source field wrong");
  a_entry_zero: assert property (decValid && !($past(pktDesc.hit) && $past(pktDesc.entStatic))
    |-> decOut.egressVid[9:4] == 6'h0)
    else $error("Egress tag entry bits not zero");
  // Mirroring, lookup, priority and tag handling
  a_tx_mirror: assert property (pktValid && mir.txEn && !next_dec.drop &&
    mir.sniffer != pktDesc.srcPort && mir.sniffer != 2'd3 &&
    (next_dec.destMask & mir.mirrored & ~portBit(mir.sniffer)) != 3'b000
    |=> decOut.destMask[$past(mir.sniffer)])
    else $error("Transmit mirror copy missing");
  a_filt_mirror: assert property (pktValid && !mir.rxFilt && next_dec.drop
    |=> decOut.destMask == 3'b000)
    else $error("Filtered packet mirrored");
  a_lookup_dest: assert property (pktValid && cls.special && cls.lookup &&
    !gic.vlanEn && portState == 6'h00 && !mir.rxEn && !mir.txEn && !next_dec.drop
    |=> decOut.destMask == ($past(pktDesc.entPorts) & ~portBit(decOut.srcPort)))
    else $error("Lookup destination not used");
  a_tag_pri: assert property (pktValid && cls.special && !cls.priCalc
    |=> decOut.pri == $past(pktDesc.firstPri))
    else $error("Tag priority not used");
  a_vlan_bypass: assert property (pktValid && cls.special && !cls.lookup &&
    !cls.vlanRules && cls.destIdx == 2'd3 && portState == 6'h00 && !next_dec.drop
    |=> decOut.destMask == ~portBit(decOut.srcPort))
    else $error("VLAN rules applied without request");
  a_strip_tag: assert property (pktValid && cls.special
    |=> (decOut.stripMask | decOut.tagMask) == decOut.destMask)
    else $error("Special tag not stripped");
  a_tag_insert: assert property (pktValid && egKind[1:0] == `SWT_KIND_SPECIAL
    |=> decOut.tagMask[0] == decOut.destMask[0])
    else $error("Tag not inserted toward CPU port");
  a_entry_bits: assert property (pktValid && pktDesc.hit && pktDesc.entStatic
    |=> decOut.egressVid[9:4] == {$past(pktDesc.entPri), $past(pktDesc.entPriEn), 1'b1,
    $past(pktDesc.entOverride)})
    else $error("Egress tag entry bits wrong");
  a_plain_kind: assert property (pktValid && inKind[1:0] != `SWT_KIND_SPECIAL &&
    pktDesc.srcPort == 2'd0 |=> decOut.stripMask == 3'b000)
    else $error("Special tag decoded on plain port");

  c_trap: cover property (decValid && decOut.monitored && !decOut.drop);
  c_mirror: cover property (pktValid && (rxM || txM) ##1 decValid);
  c_bcast: cover property (pktValid && cls.special && cls.destIdx == 2'd3);
  c_tagged: cover property (decValid && decOut.tagMask != 3'b000);
  c_lookup: cover property (pktValid && cls.special && cls.lookup);
endmodule : swt_engine

// ==== verilog/swt_pkg.sv ====
// Types shared by the switch trap, mirror and CPU tag engine
package swt_pkg;
  // Global ingress configuration fields
  typedef struct packed {
    logic vlanEn;
    logic [1:0] monPort;
    logic echo;
    logic anyHbh;
    logic otherNh;
    logic mldEn;
    logic igmpEn;
  } swt_gic_s;
  // Mirror configuration: one sniffer index, any mirrored set
  typedef struct packed {
    logic [1:0] sniffer;
    logic [2:0] mirrored;
    logic rxFilt;
    logic txEn;
    logic rxEn;
  } swt_mir_s;
  // Per-port ingress VLAN and learning bits
  typedef struct packed {
    logic [2:0] admitNonMember;
    logic [2:0] memberCheck;
    logic [2:0] admitOnly;
    logic [2:0] learnEn;
  } swt_vlan_s;
  // Parsed packet descriptor from the ingress parser
  typedef struct packed {
    logic [1:0] srcPort;
    logic ipv4;
    logic ipv6;
    logic mcast;
    logic [7:0] ipProto;
    logic [7:0] nextHdr;
    logic hbhPresent;
    logic [6:0] hbhOffset;
    logic [7:0] hbhNextHdr;
    logic [1:0] tagCount;
    logic [15:0] firstTpid;
    logic [11:0] firstVid;
    logic [2:0] firstPri;
    logic srcMember;
    logic [2:0] vlanMembers;
    logic hit;
    logic entStatic;
    logic entOverride;
    logic entPriEn;
    logic [2:0] entPri;
    logic [2:0] entPorts;
    logic [2:0] contentPri;
    logic filtered;
    logic [11:0] frameLen;
  } swt_desc_s;
  // Classification result
  typedef struct packed {
    logic igmp;
    logic mld;
    logic special;
    logic lookup;
    logic forceFwd;
    logic [1:0] destIdx;
    logic priCalc;
    logic vlanRules;
  } swt_cls_s;
  // Forwarding decision
  typedef struct packed {
    logic [1:0] srcPort;
    logic [2:0] destMask;
    logic drop;
    logic monitored;
    logic learn;
    logic [2:0] pri;
    logic [2:0] tagMask;
    logic [2:0] stripMask;
    logic [11:0] egressVid;
  } swt_dec_s;
endpackage : swt_pkg
